// >>> hdl/sbc_top.sv
/*
  SDRAM bank-state and clock-enable tracker: decodes command pins, tracks
  four banks and the global refresh, mode, self refresh, power down and
  clock suspend states, and flags illegal commands.
  Assumes command pins and the clock enable pin come from a controller on
  core_clk edges.
  // Overview of operation
  // - Write recovery: idle commands, then row active
  // - Write recovery accepts read or new write
  // - Auto-precharge recovery: precharge, or active after stop
  // - Auto refresh: nop until row cycle time
  // - Mode set: idle after two clocks
  // - Commands act only with enable high twice
  // - Low-power entry only with all banks idle
  // - Self refresh exits on rise with nop
  // - Recovery: only nop until row cycle time
  // - Enable fall suspends, rise resumes, next cycle
  // - Power down held low, rise returns idle
  // - Controller waits setup after enable rises
*/
`timescale 1ns/1ps
`include "sbc_defines.svh"
module sbc_top
  import sbc_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   clock_enable_pin,
  input  wire logic                   chip_select_n,
  input  wire logic                   row_strobe_n,
  input  wire logic                   column_strobe_n,
  input  wire logic                   write_strobe_n,
  input  wire logic [1:0]             bank_select,
  input  wire logic [`SBC_ADDR_W-1:0] address,
  output logic                        banks_idle,
  output logic                        self_refresh,
  output logic                        power_down,
  output logic                        clock_suspend,
  output logic                        refresh_busy,
  output logic                        mode_busy,
  output logic                        illegal_cmd
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic                    cke_prev;
    sbc_glob_e               glob;
    logic [`SBC_CNT_W-1:0]   cnt;
    logic [`SBC_CNT_W-1:0]   xsr_cnt;
    logic                    susp;
    logic                    idle_o;
    logic                    sr_o;
    logic                    pd_o;
    logic                    susp_o;
    logic                    ref_o;
    logic                    mrs_o;
    logic                    ill_o;
  } sbc_top_s;

  sbc_top_s  top_ff;
  sbc_top_s  nxt_top;
  sbc_cmd_e  cmd;
  logic      cke_now;
  logic      cmd_ok;
  logic      all_idle;
  sbc_bank_e bank_st [`SBC_NBANK];
  logic [`SBC_NBANK-1:0] bank_ill;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    case ({chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n})
      4'h0:    cmd = SBC_CMD_MRS;
      4'h1:    cmd = SBC_CMD_REF;
      4'h2:    cmd = SBC_CMD_PRE;
      4'h3:    cmd = SBC_CMD_ACT;
      4'h4:    cmd = SBC_CMD_WRITE;
      4'h5:    cmd = SBC_CMD_READ;
      4'h6:    cmd = SBC_CMD_BST;
      4'h7:    cmd = SBC_CMD_NOP;
      default: cmd = SBC_CMD_DESEL;
    endcase
  end

  // Enable is launched on this clock like the command pins; a synchroniser
  // would leave it two cycles behind the command that it qualifies
  assign cke_now = clock_enable_pin;
  // Per-state responses need enable high now and before, not suspended
  assign cmd_ok = cke_now && top_ff.cke_prev && !top_ff.susp &&
                  top_ff.glob == SBC_G_NORMAL;

  // ----------------------------------------------------------------------
  // Banks
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `SBC_NBANK; gi++)
    begin : g_bank
      logic hit;
      assign hit = (bank_select == 2'(gi)) ||
                   (cmd == SBC_CMD_PRE && address[`SBC_AP_BIT]);
      sbc_bank u_bank (
        .core_clk (core_clk),
        .rst      (rst),
        .cmd_ok   (cmd_ok),
        .cmd      (cmd),
        .hit      (hit),
        .auto_pre (address[`SBC_AP_BIT]),
        .state    (bank_st[gi]),
        .illegal  (bank_ill[gi])
      );
    end
  endgenerate

  always_comb
  begin
    all_idle = 1'b1;
    for (int i = 0; i < `SBC_NBANK; i++)
    begin
      if (bank_st[i] != SBC_B_IDLE)
        all_idle = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Global and clock-enable state
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_top          = top_ff;
    nxt_top.cke_prev = cke_now;
    nxt_top.ill_o    = |bank_ill;
    if (top_ff.cnt != '0)
      nxt_top.cnt = top_ff.cnt - 1'b1;
    if (top_ff.xsr_cnt != '0)
      nxt_top.xsr_cnt = top_ff.xsr_cnt - 1'b1;
    case (top_ff.glob)
      SBC_G_NORMAL:
      begin
        if (top_ff.cke_prev && !cke_now && all_idle && cmd == SBC_CMD_REF)
          nxt_top.glob = SBC_G_SELF;
        else if (!top_ff.cke_prev && !cke_now && all_idle)
        begin
          // Low with every bank idle is power down, even after a suspend start
          nxt_top.glob = SBC_G_PDOWN;
          nxt_top.susp = 1'b0;
        end
        else if (top_ff.cke_prev && !cke_now)
          nxt_top.susp = 1'b1;
        else if (!top_ff.cke_prev && cke_now)
          nxt_top.susp = 1'b0;
        else if (cmd_ok && all_idle && cmd == SBC_CMD_REF)
        begin
          nxt_top.glob = SBC_G_REFRESH;
          nxt_top.cnt  = `SBC_CNT_W'(`SBC_RC_CYC);
        end
        else if (cmd_ok && all_idle && cmd == SBC_CMD_MRS)
        begin
          nxt_top.glob = SBC_G_MRS;
          nxt_top.cnt  = `SBC_CNT_W'(`SBC_MRS_CLOCKS);
        end
        else if (cmd_ok && !all_idle && (cmd == SBC_CMD_REF || cmd == SBC_CMD_MRS))
          nxt_top.ill_o = 1'b1;
      end
      SBC_G_REFRESH, SBC_G_MRS:
      begin
        // Idle commands only, and stop in refresh; anything else with enable high now and before is flagged but time still runs
        if (top_ff.cke_prev && cke_now && cmd != SBC_CMD_DESEL && cmd != SBC_CMD_NOP &&
            !(top_ff.glob == SBC_G_REFRESH && cmd == SBC_CMD_BST))
          nxt_top.ill_o = 1'b1;
        if (top_ff.cnt <= `SBC_CNT_W'(1))
          nxt_top.glob = SBC_G_NORMAL;
      end
      SBC_G_SELF:
      begin
        if (!top_ff.cke_prev && cke_now)
        begin
          nxt_top.glob    = SBC_G_SR_RECOV;
          nxt_top.cnt     = `SBC_CNT_W'(`SBC_RC_CYC);
          nxt_top.xsr_cnt = `SBC_CNT_W'(`SBC_XSR_CYC);
          if (cmd != SBC_CMD_DESEL && cmd != SBC_CMD_NOP)
            nxt_top.ill_o = 1'b1;
        end
      end
      SBC_G_SR_RECOV:
      begin
        if (cmd != SBC_CMD_DESEL && cmd != SBC_CMD_NOP)
          nxt_top.ill_o = 1'b1;
        if (top_ff.cke_prev && !cke_now && top_ff.xsr_cnt != '0)
          nxt_top.ill_o = 1'b1;
        if (top_ff.cnt <= `SBC_CNT_W'(1))
          nxt_top.glob = SBC_G_NORMAL;
      end
      SBC_G_PDOWN:
      begin
        if (cke_now)
          nxt_top.glob = SBC_G_NORMAL;
      end
      default:
        nxt_top.glob = SBC_G_NORMAL;
    endcase
    nxt_top.idle_o = all_idle;
    nxt_top.sr_o   = nxt_top.glob == SBC_G_SELF;
    nxt_top.pd_o   = nxt_top.glob == SBC_G_PDOWN;
    nxt_top.susp_o = nxt_top.susp;
    nxt_top.ref_o  = nxt_top.glob == SBC_G_REFRESH;
    nxt_top.mrs_o  = nxt_top.glob == SBC_G_MRS;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      top_ff <= '{cke_prev: 1'b1, glob: SBC_G_NORMAL, cnt: '0,
                  xsr_cnt: '0, susp: 1'b0, idle_o: 1'b1, sr_o: 1'b0, pd_o: 1'b0,
                  susp_o: 1'b0, ref_o: 1'b0, mrs_o: 1'b0, ill_o: 1'b0};
    else
      top_ff <= nxt_top;
  end

  assign banks_idle    = top_ff.idle_o;
  assign self_refresh  = top_ff.sr_o;
  assign power_down    = top_ff.pd_o;
  assign clock_suspend = top_ff.susp_o;
  assign refresh_busy  = top_ff.ref_o;
  assign mode_busy     = top_ff.mrs_o;
  assign illegal_cmd   = top_ff.ill_o;
endmodule

// >>> hdl/sbc_defines.svh
/*
  Named constants for the SDRAM bank-state and clock-enable tracker.
  Assumes a 25 MHz core clock; times are given in ns and turned into cycles here.
*/
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

`define SBC_CLK_PERIOD_NS   40
`define SBC_WR_RECOVERY_NS  20
`define SBC_ROW_CYCLE_NS    70
`define SBC_SR_EXIT_NS      70
`define SBC_MRS_CLOCKS      2
// Least times round up to whole cycles
`define SBC_CYC(ns) (((ns) + `SBC_CLK_PERIOD_NS - 1) / `SBC_CLK_PERIOD_NS)
`define SBC_WR_CYC  `SBC_CYC(`SBC_WR_RECOVERY_NS)
`define SBC_RC_CYC  `SBC_CYC(`SBC_ROW_CYCLE_NS)
`define SBC_XSR_CYC `SBC_CYC(`SBC_SR_EXIT_NS)
`define SBC_NBANK   4
`define SBC_CNT_W   4
`define SBC_AP_BIT  10
`define SBC_ADDR_W  13

`endif

// >>> hdl/sbc_pkg.sv
/*
  Types shared by the bank-state tracker.
  Assumes the defines header is compiled in the same unit.
*/
package sbc_pkg;

  typedef enum logic [3:0] {
    SBC_CMD_DESEL, SBC_CMD_NOP, SBC_CMD_BST, SBC_CMD_READ, SBC_CMD_WRITE,
    SBC_CMD_ACT, SBC_CMD_PRE, SBC_CMD_REF, SBC_CMD_MRS
  } sbc_cmd_e;

  typedef enum logic [3:0] {
    SBC_B_IDLE, SBC_B_ACTIVE, SBC_B_WREC, SBC_B_WREC_AP, SBC_B_PRECH
  } sbc_bank_e;

  typedef enum logic [2:0] {
    SBC_G_NORMAL, SBC_G_REFRESH, SBC_G_MRS, SBC_G_SELF, SBC_G_SR_RECOV, SBC_G_PDOWN
  } sbc_glob_e;

endpackage

// >>> hdl/sbc_bank.sv
/*
  One bank's state: write recovery with and without auto precharge.
  Assumes the top decodes commands and marks with hit the ones aimed here; illegal ones are flagged here.
*/
`timescale 1ns/1ps
`include "sbc_defines.svh"
module sbc_bank
  import sbc_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      rst,
  input  wire logic      cmd_ok,
  input  wire sbc_cmd_e  cmd,
  input  wire logic      hit,
  input  wire logic      auto_pre,
  output sbc_bank_e      state,
  output logic           illegal
);
  typedef struct packed {
    sbc_bank_e                st;
    logic [`SBC_CNT_W-1:0]    cnt;
    logic                     bst_seen;
    logic                     ill;
  } sbc_bank_s;

  sbc_bank_s bank_ff;
  sbc_bank_s nxt_bank;

  always_comb
  begin
    nxt_bank     = bank_ff;
    nxt_bank.ill = 1'b0;
    if (bank_ff.cnt != '0)
    begin
      nxt_bank.cnt = bank_ff.cnt - 1'b1;
    end
    if (cmd_ok)
    begin
      case (bank_ff.st)
        SBC_B_WREC:
        begin
          if (hit && (cmd == SBC_CMD_READ || cmd == SBC_CMD_WRITE))
          begin
            nxt_bank.st = (cmd == SBC_CMD_WRITE) ? (auto_pre ? SBC_B_WREC_AP : SBC_B_WREC)
                                                 : SBC_B_ACTIVE;
            nxt_bank.cnt = `SBC_CNT_W'(`SBC_WR_CYC);
          end
          else if (hit && (cmd == SBC_CMD_ACT || cmd == SBC_CMD_PRE))
            nxt_bank.ill = 1'b1;
          else if (bank_ff.cnt <= `SBC_CNT_W'(1))
            nxt_bank.st = SBC_B_ACTIVE;
        end
        SBC_B_WREC_AP:
        begin
          if (hit && cmd == SBC_CMD_BST)
            nxt_bank.bst_seen = 1'b1;
          if (hit && (cmd == SBC_CMD_READ || cmd == SBC_CMD_WRITE ||
                      cmd == SBC_CMD_ACT || cmd == SBC_CMD_PRE))
            nxt_bank.ill = 1'b1;
          if (bank_ff.cnt <= `SBC_CNT_W'(1))
          begin
            nxt_bank.st = (bank_ff.bst_seen || (hit && cmd == SBC_CMD_BST))
                          ? SBC_B_ACTIVE : SBC_B_PRECH;
            nxt_bank.bst_seen = 1'b0;
          end
        end
        SBC_B_PRECH:
        begin
          if (bank_ff.cnt == '0)
            nxt_bank.st = SBC_B_IDLE;
        end
        default:
        begin
          if (hit && cmd == SBC_CMD_ACT)
            nxt_bank.st = SBC_B_ACTIVE;
          else if (bank_ff.st == SBC_B_ACTIVE && hit && cmd == SBC_CMD_PRE)
            nxt_bank.st = SBC_B_IDLE;
          else if (bank_ff.st == SBC_B_ACTIVE && hit && cmd == SBC_CMD_WRITE)
          begin
            nxt_bank.st  = auto_pre ? SBC_B_WREC_AP : SBC_B_WREC;
            nxt_bank.cnt = `SBC_CNT_W'(`SBC_WR_CYC);
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      bank_ff <= '{st: SBC_B_IDLE, cnt: '0, bst_seen: 1'b0, ill: 1'b0};
    else
      bank_ff <= nxt_bank;
  end

  assign state   = bank_ff.st;
  assign illegal = bank_ff.ill;
endmodule

// >>> verification/sbc_ctrl_model.sv
/*
  Controller model: drives clock enable and command pins of the tracker.
  Assumes the bench calls its tasks one at a time from a single process.
*/
`timescale 1ns/1ps
`include "sbc_defines.svh"
module sbc_ctrl_model
(
  input  wire logic                   core_clk,
  output logic                        cke,
  output logic [3:0]                  pins,
  output logic [1:0]                  bank,
  output logic [`SBC_ADDR_W-1:0]      addr
);
  initial
  begin
    cke = 1'b1;
    pins = 4'hF;
    bank = 2'h0;
    addr = '0;
  end
  // Pins change just after an edge and hold for the whole cycle
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic ap,
                     input logic ke = 1'b1);
    @(posedge core_clk);
    #1;
    cke = ke;
    pins = c;
    bank = b;
    addr = {2'h0, ap, 10'h000};
  endtask
  // Unused lines toggle, so a stale value never poses as a field
  task automatic idle();
    @(posedge core_clk);
    #1;
    pins = 4'h7;
    bank = ~bank;
    addr = ~addr;
  endtask
endmodule

// >>> verification/sbc_top_properties.sv
/*
  Port checker for the bank-state tracker, bound to sbc_top.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "sbc_defines.svh"
module sbc_chk
(
  input wire logic                   core_clk,
  input wire logic                   rst,
  input wire logic                   clock_enable_pin,
  input wire logic                   chip_select_n,
  input wire logic                   row_strobe_n,
  input wire logic                   column_strobe_n,
  input wire logic                   write_strobe_n,
  input wire logic [1:0]             bank_select,
  input wire logic [`SBC_ADDR_W-1:0] address,
  input wire logic                   banks_idle,
  input wire logic                   self_refresh,
  input wire logic                   power_down,
  input wire logic                   clock_suspend,
  input wire logic                   refresh_busy,
  input wire logic                   mode_busy,
  input wire logic                   illegal_cmd
);
  logic [3:0] pins, hi_cnt, q_cnt;
  logic       rdy;
  assign pins = {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n};
  assign rdy = clock_enable_pin && banks_idle && !mode_busy && !refresh_busy && !clock_suspend
               && !self_refresh && !power_down && q_cnt >= 4'h8;
  // Run lengths of a high enable and of quiet command cycles
  always_ff @(posedge core_clk)
  begin
    hi_cnt <= (rst || !clock_enable_pin) ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hF};
    q_cnt <= (rst || !clock_enable_pin || (!chip_select_n && pins != 4'h7)) ? 4'h0
             : q_cnt + {3'h0, q_cnt != 4'hF};
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_mode_walk;
    mode_busy[*2] ##1 !mode_busy;
  endsequence
  sequence s_ref_walk;
    refresh_busy[*2] ##1 !refresh_busy;
  endsequence
  AST_MRS_WALK: assert property (rdy && pins == 4'h0 |=> s_mode_walk)
    else $error("mode access length wrong");
  AST_REF_WALK: assert property (rdy && pins == 4'h1 |=> s_ref_walk)
    else $error("refresh length wrong");
  AST_MRS_REFUSE: assert property ($rose(mode_busy) && hi_cnt >= 4'h8 && pins == 4'h6
    |-> ##[1:2] illegal_cmd) else $error("stop in mode access not flagged");
  AST_REF_REFUSE: assert property ($rose(refresh_busy) && hi_cnt >= 4'h8 && pins == 4'h5
    |-> ##[1:2] illegal_cmd) else $error("read in refresh not flagged");
  AST_LOWPWR_IDLE: assert property (self_refresh || power_down |-> banks_idle)
    else $error("low power with a bank open");
  AST_SR_KEEP: assert property (self_refresh && !clock_enable_pin |=> self_refresh)
    else $error("self refresh left with enable low");
  AST_PD_EXIT: assert property (hi_cnt >= 4'h7 |-> !power_down)
    else $error("power down kept with enable high");
  AST_SUSP_EXIT: assert property (hi_cnt >= 4'h7 |-> !clock_suspend)
    else $error("suspend kept with enable high");
endmodule
bind sbc_top sbc_chk u_chk (.core_clk, .rst, .clock_enable_pin, .chip_select_n, .row_strobe_n,
  .column_strobe_n, .write_strobe_n, .bank_select, .address, .banks_idle, .self_refresh,
  .power_down, .clock_suspend, .refresh_busy, .mode_busy, .illegal_cmd);

// >>> verification/testbench.sv
/*
  Self-checking bench for the bank-state tracker.
  Assumes the controller model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
`include "sbc_defines.svh"
module testbench;
  localparam logic [3:0] C_DES = 4'hF, C_NOP = 4'h7, C_BST = 4'h6, C_RD = 4'h5, C_WR = 4'h4;
  localparam logic [3:0] C_ACT = 4'h3, C_PRE = 4'h2, C_REF = 4'h1, C_MRS = 4'h0;
  typedef struct packed { logic [3:0] code; logic [7:0] ill; } sbc_row_s;
  localparam sbc_row_s ROWS [9] = '{'{C_DES, 8'h00}, '{C_NOP, 8'h00}, '{C_BST, 8'h01},
    '{C_RD, 8'h01}, '{C_WR, 8'h01}, '{C_ACT, 8'h01}, '{C_PRE, 8'h01}, '{C_REF, 8'h01},
    '{C_MRS, 8'h01}};
  logic                   core_clk;
  logic                   rst;
  logic                   cke;
  logic [3:0]             pins;
  logic [1:0]             bank;
  logic [`SBC_ADDR_W-1:0] addr;
  logic                   banks_idle, self_refresh, power_down, clock_suspend;
  logic                   refresh_busy, mode_busy, illegal_cmd;
  logic [7:0]             n_ill, n_ref, n_mode;
  int                     errors, cmp_count;
  sbc_ctrl_model ctl (.core_clk, .cke, .pins, .bank, .addr);
  sbc_top uut (.core_clk, .rst, .clock_enable_pin(cke), .chip_select_n(pins[3]),
    .row_strobe_n(pins[2]), .column_strobe_n(pins[1]), .write_strobe_n(pins[0]),
    .bank_select(bank), .address(addr), .banks_idle, .self_refresh, .power_down,
    .clock_suspend, .refresh_busy, .mode_busy, .illegal_cmd);
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic clr();
    n_ill = 8'h00;
    n_ref = 8'h00;
    n_mode = 8'h00;
  endtask
  // Outputs are read one step after the edge, once its updates have landed
  task automatic tally();
    n_ill += {7'h00, illegal_cmd};
    n_ref += {7'h00, refresh_busy};
    n_mode += {7'h00, mode_busy};
  endtask
  task automatic op(input logic [3:0] c, input logic [1:0] b, input logic ap,
                    input logic ke = 1'b1);
    ctl.cmd(c, b, ap, ke);
    tally();
  endtask
  task automatic run(input int n);
    repeat (n)
    begin
      ctl.idle();
      tally();
    end
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    clr();
    repeat (3) @(posedge core_clk);
    #1;
    chk({1'b0, banks_idle, self_refresh, power_down, clock_suspend, refresh_busy,
         mode_busy, illegal_cmd}, 8'h40);
    rst = 1'b0;
    run(10);
    foreach (ROWS[i])
    begin
      clr();
      op(C_MRS, 2'h0, 1'b0);
      op(ROWS[i].code, 2'h1, 1'b0);
      run(9);
      chk(n_ill, ROWS[i].ill);
      chk(n_mode, 8'h02);
      chk({7'h00, banks_idle}, 8'h01);
    end
    clr();
    op(C_REF, 2'h0, 1'b0);
    op(C_RD, 2'h2, 1'b0);
    run(6);
    chk(n_ref, 8'h02);
    chk(n_ill, 8'h01);
    op(C_ACT, 2'h0, 1'b0);
    run(3);
    clr();
    op(C_WR, 2'h0, 1'b0);
    op(C_ACT, 2'h0, 1'b0);
    run(2);
    op(C_WR, 2'h0, 1'b0);
    op(C_RD, 2'h0, 1'b0);
    run(3);
    chk(n_ill, 8'h01);
    clr();
    op(C_WR, 2'h0, 1'b1);
    op(C_RD, 2'h0, 1'b0);
    run(9);
    chk(n_ill, 8'h01);
    chk({7'h00, banks_idle}, 8'h01);
    op(C_ACT, 2'h0, 1'b0);
    run(3);
    op(C_WR, 2'h0, 1'b1);
    op(C_BST, 2'h0, 1'b0);
    run(6);
    chk({7'h00, banks_idle}, 8'h00);
    op(C_NOP, 2'h0, 1'b0, 1'b0);
    run(6);
    chk({7'h00, clock_suspend}, 8'h01);
    op(C_NOP, 2'h0, 1'b0, 1'b1);
    run(6);
    chk({7'h00, clock_suspend}, 8'h00);
    op(C_PRE, 2'h0, 1'b0);
    run(9);
    op(C_NOP, 2'h0, 1'b0, 1'b0);
    run(6);
    clr();
    op(C_MRS, 2'h0, 1'b0, 1'b0);
    run(3);
    chk({7'h00, power_down}, 8'h01);
    chk(n_mode, 8'h00);
    op(C_NOP, 2'h0, 1'b0, 1'b1);
    run(9);
    chk({7'h00, power_down}, 8'h00);
    op(C_REF, 2'h0, 1'b0, 1'b0);
    run(6);
    chk({7'h00, self_refresh}, 8'h01);
    op(C_NOP, 2'h0, 1'b0, 1'b1);
    run(12);
    chk({7'h00, self_refresh}, 8'h00);
    clr();
    op(C_MRS, 2'h0, 1'b0);
    run(4);
    chk(n_mode, 8'h02);
    stop_test();
  end
  // Whole run is some 230 cycles
  initial
  begin
    #(40 * 2000);
    errors++;
    stop_test();
  end
endmodule
